// ### hdl/cmh_host.sv
`include "cmh_defs.svh"
`default_nettype none
module cmh_host
	import cmh_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   req_valid_in,
	output logic                        req_ready_out,
	input  wire cmh_op_t                req_op_in,
	input  wire logic [`CMH_ADDR_W-1:0] req_addr_in,
	input  wire logic [1:0]             req_lanes_in,
	input  wire logic [`CMH_DATA_W-1:0] req_wdata_in,
	input  wire logic                   ext_card_in,
	input  wire logic                   disk_emulation_mode_in,
	output var logic                    rsp_valid_out,
	output var logic [`CMH_DATA_W-1:0]  rsp_rdata_out,
	output var logic                    rsp_error_out,
	output var logic                    rsp_wide_out,
	output var logic [`CMH_ADDR_W-1:0]  card_addr_out,
	output var logic [1:0]              byte_lane_select_n_out,
	output var logic                    attribute_select_n_out,
	output var logic                    output_strobe_n_out,
	output var logic                    write_strobe_n_out,
	output var logic                    io_read_strobe_n_out,
	output var logic                    io_write_strobe_n_out,
	input  wire logic [`CMH_DATA_W-1:0] data_in,
	output var logic [`CMH_DATA_W-1:0]  data_out,
	output var logic                    data_oe_n_out,
	input  wire logic                   cycle_extend_n_in,
	input  wire logic                   input_ack_n_in,
	input  wire logic                   wide_io_flag_n_in
);
	localparam logic [7:0] C_ADDR_SU  = 8'(`CMH_C_ADDR_SU);
	localparam logic [7:0] C_MEM_STB  = 8'(`CMH_C_MEM_STB);
	localparam logic [7:0] C_IO_STB   = 8'(`CMH_C_IO_STB);
	localparam logic [7:0] C_WAIT_DLY = 8'(`CMH_C_WAIT_DLY);
	localparam logic [7:0] C_HOLD     = 8'(`CMH_C_HOLD);
	localparam logic [7:0] C_WMAX     = 8'(`CMH_C_WAIT_MAX);
	localparam logic [7:0] C_WMAX_X   = 8'(`CMH_C_WAIT_MAX_X);

	cmh_state_t             state_reg;
	cmh_op_t                op_reg;
	logic [7:0]             cnt_reg;
	logic [7:0]             wcnt_reg;
	logic [`CMH_DATA_W-1:0] rdata_reg;
	logic                   ext_seen_reg;
	logic                   ext_s1_reg, ext_s2_reg;
	logic                   ack_s1_reg, ack_s2_reg;
	logic                   wide_s1_reg, wide_s2_reg;
	logic [`CMH_DATA_W-1:0] din_s1_reg, din_s2_reg;

	// Minimum low time for the strobe of the current operation.
	function automatic logic [7:0] cmh_stb_min(input cmh_op_t op);
		return (op == CMH_MEM_RD || op == CMH_MEM_WR) ? C_MEM_STB : C_IO_STB;
	endfunction : cmh_stb_min

	wire logic is_read   = (op_reg == CMH_MEM_RD) || (op_reg == CMH_IO_RD);
	wire logic extending = !ext_s2_reg;
	wire logic wait_lim  = wcnt_reg >= (ext_card_in ? C_WMAX_X : C_WMAX);
	wire logic stb_met   = cnt_reg >= cmh_stb_min(op_reg);
	assign req_ready_out = (state_reg == CMH_IDLE);

	always_ff @(posedge clk_in) begin
		ext_s1_reg  <= cycle_extend_n_in;
		ext_s2_reg  <= ext_s1_reg;
		ack_s1_reg  <= input_ack_n_in;
		ack_s2_reg  <= ack_s1_reg;
		wide_s1_reg <= wide_io_flag_n_in;
		wide_s2_reg <= wide_s1_reg;
		din_s1_reg  <= data_in;
		din_s2_reg  <= din_s1_reg;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= CMH_IDLE;
			cnt_reg   <= 8'h00;
		end else begin
			case (state_reg)
				CMH_IDLE: begin
					cnt_reg <= 8'h00;
					if (req_valid_in) begin
						state_reg <= CMH_SETUP;
					end
				end
				CMH_SETUP: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg + 8'h01 >= C_ADDR_SU) begin
						state_reg <= CMH_STROBE;
						cnt_reg   <= 8'h00;
					end
				end
				CMH_STROBE: begin
					cnt_reg <= cnt_reg + 8'h01;
					// Extend is sampled only once the card's assert window has elapsed; the strobe ends only after window plus sync.
					if (extending && cnt_reg > C_WAIT_DLY) begin
						state_reg <= CMH_WAITX;
					end else if (stb_met && cnt_reg > C_WAIT_DLY + 8'h02) begin
						state_reg <= CMH_HOLD;
						cnt_reg   <= 8'h00;
					end
				end
				CMH_WAITX: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (wait_lim) begin
						state_reg <= CMH_HOLD;
						cnt_reg   <= 8'h00;
					end else if (!extending && stb_met) begin
						state_reg <= CMH_HOLD;
						cnt_reg   <= 8'h00;
					end
				end
				CMH_HOLD: begin
					cnt_reg <= cnt_reg + 8'h01;
					if (cnt_reg + 8'h01 >= C_HOLD) begin
						state_reg <= CMH_DONE;
					end
				end
				CMH_DONE: begin
					state_reg <= CMH_IDLE;
				end
				default: begin
					state_reg <= CMH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wcnt_reg     <= 8'h00;
			ext_seen_reg <= 1'b0;
		end else if (state_reg == CMH_WAITX) begin
			wcnt_reg     <= wcnt_reg + 8'h01;
			ext_seen_reg <= 1'b1;
		end else if (state_reg == CMH_IDLE) begin
			wcnt_reg     <= 8'h00;
			ext_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			op_reg                 <= CMH_MEM_RD;
			card_addr_out          <= '0;
			byte_lane_select_n_out <= 2'h3;
			attribute_select_n_out <= 1'b1;
			data_out               <= '0;
			data_oe_n_out          <= 1'b1;
		end else if (state_reg == CMH_IDLE && req_valid_in) begin
			op_reg                 <= req_op_in;
			card_addr_out          <= req_addr_in;
			// Both lanes need an even address; an odd 16-bit request drops to the low lane.
			byte_lane_select_n_out <= (req_lanes_in == 2'h3 && req_addr_in[0]) ?
				2'h2 : ~req_lanes_in;
			// Attribute select stays high: common memory and I/O only, also for disk mode.
			attribute_select_n_out <= 1'b1;
			data_out               <= req_wdata_in;
			data_oe_n_out          <= (req_op_in == CMH_MEM_RD || req_op_in == CMH_IO_RD);
		end else if (state_reg == CMH_DONE) begin
			byte_lane_select_n_out <= 2'h3;
			data_oe_n_out          <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			output_strobe_n_out   <= 1'b1;
			write_strobe_n_out    <= 1'b1;
			io_read_strobe_n_out  <= 1'b1;
			io_write_strobe_n_out <= 1'b1;
		end else begin
			output_strobe_n_out   <= !(state_reg inside {CMH_SETUP, CMH_STROBE, CMH_WAITX} &&
				op_reg == CMH_MEM_RD && state_reg != CMH_SETUP);
			write_strobe_n_out    <= !((state_reg == CMH_STROBE || state_reg == CMH_WAITX) &&
				op_reg == CMH_MEM_WR) || (state_reg == CMH_WAITX && (wait_lim ||
				(!extending && stb_met))) || (state_reg == CMH_STROBE && stb_met &&
				!extending && cnt_reg > C_WAIT_DLY + 8'h02);
			io_read_strobe_n_out  <= !((state_reg == CMH_STROBE || state_reg == CMH_WAITX) &&
				op_reg == CMH_IO_RD);
			io_write_strobe_n_out <= !((state_reg == CMH_STROBE || state_reg == CMH_WAITX) &&
				op_reg == CMH_IO_WR);
		end
	end

	// Read data is latched at the end of the strobe phase, after access time has passed.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_reg <= '0;
		end else if ((state_reg == CMH_STROBE || state_reg == CMH_WAITX) && is_read) begin
			rdata_reg <= din_s2_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
			rsp_error_out <= 1'b0;
			rsp_wide_out  <= 1'b0;
		end else begin
			rsp_valid_out <= (state_reg == CMH_HOLD) && (cnt_reg + 8'h01 >= C_HOLD);
			if (state_reg == CMH_HOLD && cnt_reg == 8'h00) begin
				rsp_rdata_out <= rdata_reg;
				rsp_error_out <= ext_seen_reg && wait_lim;
				// In disk emulation mode the ack is not used by the card.
				rsp_wide_out  <= !wide_s2_reg && (disk_emulation_mode_in || op_reg != CMH_IO_RD ||
					!ack_s2_reg);
			end
		end
	end

	wire logic strobe_low = !output_strobe_n_out || !write_strobe_n_out ||
		!io_read_strobe_n_out || !io_write_strobe_n_out;

	a_idle_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_reg == CMH_IDLE |=> !strobe_low)
		else $error("strobe low in idle");
	a_io_rd_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$fell(io_read_strobe_n_out) |-> !io_read_strobe_n_out [*7])
		else $error("io read strobe too short");
	a_io_wr_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$fell(io_write_strobe_n_out) |-> !io_write_strobe_n_out [*7])
		else $error("io write strobe too short");
	a_mem_wr_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$fell(write_strobe_n_out) |-> !write_strobe_n_out [*6])
		else $error("write strobe too short");
	a_wr_wait_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_reg == CMH_WAITX && extending && !wait_lim |=> !write_strobe_n_out ||
		op_reg != CMH_MEM_WR)
		else $error("write strobe raised during extend");
	a_wait_bound: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(state_reg == CMH_WAITX) |-> ##[1:125] state_reg != CMH_WAITX)
		else $error("extend wait unbounded");
	a_lane_even: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		byte_lane_select_n_out == 2'h0 |-> !card_addr_out[0])
		else $error("16-bit access at odd address");
	a_attr_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		attribute_select_n_out)
		else $error("attribute select driven low");
	a_done_resp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_reg == CMH_DONE |-> rsp_valid_out)
		else $error("response missing");

	c_mem_rd: cover property (@(posedge clk_in) $rose(output_strobe_n_out));
	c_io_wr: cover property (@(posedge clk_in) $rose(io_write_strobe_n_out));
	c_extended: cover property (@(posedge clk_in) $rose(state_reg == CMH_WAITX));
	c_timeout: cover property (@(posedge clk_in) rsp_valid_out && rsp_error_out);
endmodule : cmh_host
`default_nettype wire

// ### hdl/cmh_defs.svh
`ifndef CMH_DEFS_SVH
`define CMH_DEFS_SVH

`define CMH_CLK_PERIOD_NS   25
`define CMH_CYC(ns)         (((ns) + `CMH_CLK_PERIOD_NS - 1) / `CMH_CLK_PERIOD_NS)
`define CMH_T_ADDR_SU_NS    70
`define CMH_T_MEM_STB_NS    150
`define CMH_T_MEM_ACC_NS    125
`define CMH_T_IO_STB_NS     165
`define CMH_T_IO_ACC_NS     100
`define CMH_T_WAIT_DLY_NS   35
`define CMH_T_HOLD_NS       30
`define CMH_T_WAIT_MAX_NS   350
`define CMH_T_WAIT_MAX_X_NS 3000
`define CMH_C_ADDR_SU       `CMH_CYC(`CMH_T_ADDR_SU_NS)
`define CMH_C_MEM_STB       `CMH_CYC(`CMH_T_MEM_STB_NS)
`define CMH_C_MEM_ACC       `CMH_CYC(`CMH_T_MEM_ACC_NS)
`define CMH_C_IO_STB        `CMH_CYC(`CMH_T_IO_STB_NS)
`define CMH_C_IO_ACC        `CMH_CYC(`CMH_T_IO_ACC_NS)
`define CMH_C_WAIT_DLY      `CMH_CYC(`CMH_T_WAIT_DLY_NS)
`define CMH_C_HOLD          `CMH_CYC(`CMH_T_HOLD_NS)
`define CMH_C_WAIT_MAX      (`CMH_T_WAIT_MAX_NS / `CMH_CLK_PERIOD_NS)
`define CMH_C_WAIT_MAX_X    (`CMH_T_WAIT_MAX_X_NS / `CMH_CLK_PERIOD_NS)
`define CMH_ADDR_W          11
`define CMH_DATA_W          16

`endif

// ### hdl/cmh_pkg.sv
`default_nettype none
package cmh_pkg;
	typedef enum logic [1:0] {
		CMH_MEM_RD = 2'h0,
		CMH_MEM_WR = 2'h1,
		CMH_IO_RD  = 2'h2,
		CMH_IO_WR  = 2'h3
	} cmh_op_t;

	typedef enum logic [5:0] {
		CMH_IDLE  = 6'h01,
		CMH_SETUP = 6'h02,
		CMH_STROBE = 6'h04,
		CMH_WAITX = 6'h08,
		CMH_HOLD  = 6'h10,
		CMH_DONE  = 6'h20
	} cmh_state_t;
endpackage : cmh_pkg
`default_nettype wire

// ### testbench/cmh_card_model.sv
`default_nettype none
module cmh_card_model (
	input  wire logic        clk_in,
	input  wire logic [10:0] addr_in,
	input  wire logic [1:0]  lanes_n_in,
	input  wire logic        output_strobe_n_in,
	input  wire logic        write_strobe_n_in,
	input  wire logic        io_read_strobe_n_in,
	input  wire logic        io_write_strobe_n_in,
	input  wire logic        disk_mode_in,
	input  wire logic [7:0]  wait_cyc_in,
	input  wire logic [15:0] bus_in,
	output logic [15:0]      drive_out,
	output logic             drive_en_out,
	output logic             cycle_extend_n_out,
	output logic             input_ack_n_out,
	output logic             wide_io_flag_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	logic [8:0]  cnt;
	logic        any_lo;
	logic        we_prev;
	assign any_lo = !(output_strobe_n_in & write_strobe_n_in & io_read_strobe_n_in
		& io_write_strobe_n_in);
	// Extend falls one cycle after the strobe and lasts the commanded count.
	assign cycle_extend_n_out = !(any_lo && cnt >= 9'h1 &&
		cnt < {1'b0, wait_cyc_in} + 9'h1);
	assign drive_en_out = (!output_strobe_n_in || !io_read_strobe_n_in) &&
		cnt >= 9'h2;
	assign drive_out = !io_read_strobe_n_in ? {5'h18, addr_in} : mem[addr_in[3:0]];
	assign input_ack_n_out = io_read_strobe_n_in || disk_mode_in;
	assign wide_io_flag_n_out = !addr_in[3];
	always_ff @(posedge clk_in) begin
		cnt <= any_lo ? cnt + 9'h1 : 9'h0;
		we_prev <= write_strobe_n_in;
		if (write_strobe_n_in && !we_prev) begin
			if (!lanes_n_in[0]) mem[addr_in[3:0]][7:0] <= bus_in[7:0];
			if (!lanes_n_in[1]) mem[addr_in[3:0]][15:8] <= bus_in[15:8];
		end
	end
endmodule : cmh_card_model
`default_nettype wire

// ### testbench/tb_card_memory_io_cycle_handshake.sv
`default_nettype none
module tb_card_memory_io_cycle_handshake;
	timeunit 1ns;
	timeprecision 1ps;
	import cmh_pkg::*;
	logic clk_in = 0, sys_rst_in = 1, req_valid = 0, ext_card = 0, disk = 0;
	cmh_op_t req_op = CMH_MEM_RD;
	logic [10:0] req_addr = 11'h0, card_addr;
	logic [1:0]  req_lanes = 2'h3, lanes_n, lanes_seen;
	logic [15:0] req_wdata = 16'h0, rdata, host_d, card_d, bus;
	logic [7:0]  wait_cyc = 8'h0;
	logic ready, rsp_v, rsp_err, rsp_wide, attr_n, oe_n, we_n, io_rd_n, io_wr_n, doe_n, card_en;
	logic ext_n, ack_n, wide_n, we_prev = 1;
	int fails = 0, checks = 0, low_n = 0, last_w = 0;
	always #12.5 clk_in = ~clk_in;
	assign bus = !doe_n ? host_d : card_en ? card_d : 16'h0000;
	cmh_host dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid),
		.req_ready_out(ready), .req_op_in(req_op), .req_addr_in(req_addr),
		.req_lanes_in(req_lanes), .req_wdata_in(req_wdata), .ext_card_in(ext_card),
		.disk_emulation_mode_in(disk), .rsp_valid_out(rsp_v), .rsp_rdata_out(rdata),
		.rsp_error_out(rsp_err), .rsp_wide_out(rsp_wide), .card_addr_out(card_addr),
		.byte_lane_select_n_out(lanes_n), .attribute_select_n_out(attr_n),
		.output_strobe_n_out(oe_n), .write_strobe_n_out(we_n), .io_read_strobe_n_out(io_rd_n),
		.io_write_strobe_n_out(io_wr_n), .data_in(bus), .data_out(host_d),
		.data_oe_n_out(doe_n), .cycle_extend_n_in(ext_n), .input_ack_n_in(ack_n),
		.wide_io_flag_n_in(wide_n));
	cmh_card_model card (.clk_in(clk_in), .addr_in(card_addr), .lanes_n_in(lanes_n),
		.output_strobe_n_in(oe_n), .write_strobe_n_in(we_n), .io_read_strobe_n_in(io_rd_n),
		.io_write_strobe_n_in(io_wr_n), .disk_mode_in(disk), .wait_cyc_in(wait_cyc),
		.bus_in(bus), .drive_out(card_d), .drive_en_out(card_en), .cycle_extend_n_out(ext_n),
		.input_ack_n_out(ack_n), .wide_io_flag_n_out(wide_n));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Strobe widths and lanes are watched on the pins; write strobe must wait for extend.
	always @(negedge clk_in) begin
		if (!(oe_n & we_n & io_rd_n & io_wr_n)) begin
			low_n++;
			lanes_seen = lanes_n;
		end else if (low_n != 0) begin
			last_w = low_n;
			low_n = 0;
		end
		if (!we_prev && we_n) chk("we_rise_extend", 16'h1, {15'h0, ext_n});
		we_prev = we_n;
	end
	task automatic op(input cmh_op_t o, input logic [10:0] a, input logic [1:0] l,
		input logic [15:0] d, input logic [7:0] w);
		int n;
		@(negedge clk_in);
		while (ready !== 1'b1) @(negedge clk_in);
		req_op = o;
		req_addr = a;
		req_lanes = l;
		req_wdata = d;
		wait_cyc = w;
		req_valid = 1'b1;
		@(negedge clk_in);
		req_valid = 0;
		chk("ready_busy", 16'h0, {15'h0, ready});
		n = 0;
		while (rsp_v !== 1'b1 && n < 400) begin
			@(negedge clk_in);
			n++;
		end
		chk("rsp_seen", 16'h1, {15'h0, rsp_v});
	endtask : op
	task automatic t_mem;
		op(CMH_MEM_WR, 11'h004, 2'h3, 16'h1234, 8'h0);
		chk("we_width_ok", 16'h1, {15'h0, last_w >= 6});
		op(CMH_MEM_WR, 11'h006, 2'h3, 16'hbeef, 8'h3);
		op(CMH_MEM_RD, 11'h004, 2'h3, 16'h0, 8'h0);
		chk("mem_rdata", 16'h1234, rdata);
		op(CMH_MEM_RD, 11'h006, 2'h3, 16'h0, 8'h3);
		chk("mem_rdata_ext", 16'hbeef, rdata);
		chk("mem_error", 16'h0, {15'h0, rsp_err});
		$display("test t_mem done");
	endtask : t_mem
	task automatic t_lanes;
		op(CMH_MEM_WR, 11'h004, 2'h1, 16'h00aa, 8'h0);
		chk("lanes_low", 16'h2, {14'h0, lanes_seen});
		op(CMH_MEM_WR, 11'h004, 2'h2, 16'h5600, 8'h0);
		chk("lanes_high", 16'h1, {14'h0, lanes_seen});
		op(CMH_MEM_RD, 11'h005, 2'h3, 16'h0, 8'h0);
		chk("lanes_odd", 16'h2, {14'h0, lanes_seen});
		op(CMH_MEM_RD, 11'h004, 2'h3, 16'h0, 8'h0);
		chk("lanes_word", 16'h56aa, rdata);
		$display("test t_lanes done");
	endtask : t_lanes
	task automatic t_io;
		op(CMH_IO_RD, 11'h008, 2'h3, 16'h0, 8'h0);
		chk("io_rdata", 16'hc008, rdata);
		chk("io_wide", 16'h1, {15'h0, rsp_wide});
		op(CMH_IO_RD, 11'h002, 2'h3, 16'h0, 8'h2);
		chk("io_rdata_ext", 16'hc002, rdata);
		chk("io_narrow", 16'h0, {15'h0, rsp_wide});
		chk("io_rd_width_ok", 16'h1, {15'h0, last_w >= 7});
		op(CMH_IO_WR, 11'h00a, 2'h3, 16'h7777, 8'h3);
		chk("io_wr_width_ok", 16'h1, {15'h0, last_w >= 7});
		$display("test t_io done");
	endtask : t_io
	task automatic t_disk;
		disk = 1;
		op(CMH_IO_RD, 11'h00c, 2'h3, 16'h0, 8'h0);
		chk("disk_rdata", 16'hc00c, rdata);
		chk("disk_wide", 16'h1, {15'h0, rsp_wide});
		chk("disk_attr", 16'h1, {15'h0, attr_n});
		disk = 0;
		$display("test t_disk done");
	endtask : t_disk
	task automatic t_timeout;
		op(CMH_MEM_RD, 11'h004, 2'h3, 16'h0, 8'd200);
		chk("tmo_plain", 16'h1, {15'h0, rsp_err});
		// The testbench selects the longer extend limit by driving ext_card_in high.
		ext_card = 1;
		op(CMH_IO_WR, 11'h002, 2'h3, 16'h1111, 8'd100);
		chk("tmo_ext_ok", 16'h0, {15'h0, rsp_err});
		op(CMH_IO_WR, 11'h002, 2'h3, 16'h2222, 8'd200);
		chk("tmo_ext", 16'h1, {15'h0, rsp_err});
		ext_card = 0;
		$display("test t_timeout done");
	endtask : t_timeout
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		sys_rst_in = 0;
		t_mem();
		t_lanes();
		t_io();
		t_disk();
		t_timeout();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		give_verdict();
	end
endmodule : tb_card_memory_io_cycle_handshake
`default_nettype wire
